// File: include/dcff_pkg.sv
// shared constants for the dual-clock field fifo
package dcff_pkg;
  localparam int               FIFO_WORDS     = 393216;
  localparam int               PTR_BITS       = 19;
  localparam int               BYTE_BITS      = 8;
  localparam int               PICTURE_BYTES  = 819 * 480;
  localparam int               MIN_LAG        = 128;
  localparam int               PTR_RESET      = 0;
  localparam int               REFRESH_CYCLES = 64;
  localparam logic [7:0]       OUT_RESET      = 8'h00;
endpackage : dcff_pkg

// File: include/dcff_ptr_if.sv
// pointer control carrier between the port logic and a pointer counter
`timescale 1ns/1ps
interface dcff_ptr_if #(parameter int AW = 19);
  logic          adv;
  logic          clr;
  logic [AW-1:0] ptr;
  modport ctl (output adv, output clr, input ptr);
  modport cnt (input adv, input clr, output ptr);
endinterface : dcff_ptr_if

// File: src/dcff_ptr.sv
// wrapping address pointer with clear, used for both ports
`timescale 1ns/1ps
module dcff_ptr #(
  parameter int DEPTH = dcff_pkg::FIFO_WORDS,
  parameter int AW    = dcff_pkg::PTR_BITS
) (
  input wire logic clk,
  input wire logic rst_n,
  dcff_ptr_if.cnt  pi
);
  localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);

  if (DEPTH < 2 || DEPTH > (1 << AW))
    $error("pointer width cannot address depth");

  logic [AW-1:0] ptr_q;
  logic [AW-1:0] ptr_d;
  logic [AW-1:0] base;

  always_comb
  begin
    base  = pi.clr ? AW'(dcff_pkg::PTR_RESET) : ptr_q;
    ptr_d = base;
    if (pi.adv)
    begin
      ptr_d = (base == LAST) ? '0 : base + AW'(1);
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      ptr_q <= AW'(dcff_pkg::PTR_RESET);
    else
      ptr_q <= ptr_d;
  end

  assign pi.ptr = ptr_q;
endmodule : dcff_ptr

// File: src/dcff_xfer.sv
// toggle handshake carrying a word from one clock domain to another
`timescale 1ns/1ps
module dcff_xfer #(
  parameter int W = dcff_pkg::PTR_BITS
) (
  input  wire logic         src_clk,
  input  wire logic         src_rst_n,
  input  wire logic [W-1:0] src_word,
  input  wire logic         dst_clk,
  input  wire logic         dst_rst_n,
  output logic      [W-1:0] dst_word
);
  logic         req_q, req_d;
  logic [W-1:0] hold_q, hold_d;
  logic         ack_s1_q, ack_s2_q;
  logic         req_s1_q, req_s2_q;
  logic         seen_q, seen_d;
  logic [W-1:0] word_q, word_d;

  // hold_q is stable while the request is outstanding, so a plain capture is safe
  always_comb
  begin
    req_d  = req_q;
    hold_d = hold_q;
    if (ack_s2_q == req_q)
    begin
      hold_d = src_word;
      req_d  = ~req_q;
    end
  end

  always_ff @(posedge src_clk)
  begin
    ack_s1_q <= seen_q;
    ack_s2_q <= ack_s1_q;
    if (!src_rst_n)
    begin
      req_q  <= 1'b0;
      hold_q <= '0;
    end
    else
    begin
      req_q  <= req_d;
      hold_q <= hold_d;
    end
  end

  always_comb
  begin
    seen_d = seen_q;
    word_d = word_q;
    if (req_s2_q != seen_q)
    begin
      word_d = hold_q;
      seen_d = req_s2_q;
    end
  end

  always_ff @(posedge dst_clk)
  begin
    req_s1_q <= req_q;
    req_s2_q <= req_s1_q;
    if (!dst_rst_n)
    begin
      seen_q <= 1'b0;
      word_q <= '0;
    end
    else
    begin
      seen_q <= seen_d;
      word_q <= word_d;
    end
  end

  assign dst_word = word_q;
endmodule : dcff_xfer

// File: src/dcff_field_fifo.sv
// field fifo: write port on clk, read port on rd_clk, shared byte storage
`timescale 1ns/1ps
module dcff_field_fifo #(
  parameter int DEPTH = dcff_pkg::FIFO_WORDS,
  parameter int AW    = dcff_pkg::PTR_BITS
) (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       wr_en_n,
  input  wire logic       wr_ptr_clear_n,
  input  wire logic [7:0] wr_byte_in,
  input  wire logic       rd_clk,
  input  wire logic       rd_en_n,
  input  wire logic       rd_out_en_n,
  input  wire logic       rd_ptr_clear_n,
  input  wire logic       factory_test_pin,
  output logic      [7:0] rd_byte_out,
  output logic            rd_byte_oe_n,
  output logic            rd_lag_ok,
  output logic            refresh_stb
);
  localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);
  localparam logic [AW:0]   WRAP = (AW + 1)'(DEPTH);
  localparam logic [AW:0]   LAG_MIN = (AW + 1)'(dcff_pkg::MIN_LAG);
  localparam logic [7:0]    REF_LAST = 8'(dcff_pkg::REFRESH_CYCLES - 1);

  if (DEPTH < dcff_pkg::PICTURE_BYTES)
    $error("depth too small for one picture");
  if (DEPTH > (1 << AW) || DEPTH < 2)
    $error("pointer width cannot address depth");
  if (dcff_pkg::MIN_LAG >= DEPTH)
    $error("depth too small for the read lag window");

  // flip-flop storage; the read port indexes it from its own clock
  logic [7:0] mem_q [DEPTH];

  // reset as seen by the read domain, needed by the read pointer below
  logic       rd_rst_s1_q;
  logic       rd_rst_n_q;

  dcff_ptr_if #(.AW(AW)) wp ();
  dcff_ptr_if #(.AW(AW)) rp ();

  dcff_ptr #(.DEPTH(DEPTH), .AW(AW)) u_wr_ptr (
    .clk   (clk),
    .rst_n (rst_n),
    .pi    (wp)
  );

  dcff_ptr #(.DEPTH(DEPTH), .AW(AW)) u_rd_ptr (
    .clk   (rd_clk),
    .rst_n (rd_rst_n_q),
    .pi    (rp)
  );

  // write port
  logic          wr_act;
  logic          wr_clr_go;
  logic          wr_pend_q, wr_pend_d;
  logic [AW-1:0] wr_addr;
  logic          wb_vld_q, wb_vld_d;
  logic [AW-1:0] wb_addr_q, wb_addr_d;
  logic [7:0]    wb_data_q, wb_data_d;
  logic [7:0]    ref_cnt_q, ref_cnt_d;
  logic          ref_stb_q, ref_stb_d;

  always_comb
  begin
    wr_act    = ~wr_en_n;
    // a clear seen while writes are held waits in wr_pend_q
    wr_clr_go = wr_act & (~wr_ptr_clear_n | wr_pend_q);
    wr_pend_d = wr_act ? 1'b0 : (wr_pend_q | ~wr_ptr_clear_n);
    wp.adv    = wr_act;
    wp.clr    = wr_clr_go;
    wr_addr   = wr_clr_go ? AW'(dcff_pkg::PTR_RESET) : wp.ptr;
    // one-byte input buffer commits a cycle late; a clear aims the accepted byte at word zero
    wb_vld_d  = wr_act;
    wb_addr_d = wr_addr;
    wb_data_d = wr_act ? wr_byte_in : wb_data_q;
    // clk is the faster port clock, so refresh pacing runs here
    ref_cnt_d = (ref_cnt_q == REF_LAST) ? 8'h00 : ref_cnt_q + 8'h01;
    ref_stb_d = (ref_cnt_q == REF_LAST);
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      wr_pend_q <= 1'b0;
      wb_vld_q  <= 1'b0;
      wb_addr_q <= '0;
      wb_data_q <= 8'h00;
      ref_cnt_q <= 8'h00;
      ref_stb_q <= 1'b0;
    end
    else
    begin
      wr_pend_q <= wr_pend_d;
      wb_vld_q  <= wb_vld_d;
      wb_addr_q <= wb_addr_d;
      wb_data_q <= wb_data_d;
      ref_cnt_q <= ref_cnt_d;
      ref_stb_q <= ref_stb_d;
    end
  end

  // late commit keeps a same-address read on the previous field
  always_ff @(posedge clk)
  begin
    if (wb_vld_q)
      mem_q[wb_addr_q] <= wb_data_q;
  end

  assign refresh_stb = ref_stb_q;

  // read port
  logic          tst_s1_q;
  logic          tst_s2_q;
  logic          rd_act;
  logic          rd_drive;
  logic          rd_clr_go;
  logic          rd_pend_q, rd_pend_d;
  logic [AW-1:0] rd_addr;
  logic [7:0]    rd_word;
  logic [7:0]    dout_q, dout_d;
  logic          oe_n_q, oe_n_d;
  logic [AW-1:0] wr_snap;
  logic [AW:0]   lag;
  logic          lag_ok_q, lag_ok_d;

  // reset and test strap enter the read domain through two stages
  always_ff @(posedge rd_clk)
  begin
    rd_rst_s1_q <= rst_n;
    rd_rst_n_q  <= rd_rst_s1_q;
    tst_s1_q    <= factory_test_pin;
    tst_s2_q    <= tst_s1_q;
  end

  // whole-pointer handshake, not gray code: a clear makes the pointer jump
  dcff_xfer #(.W(AW)) u_wr_xfer (
    .src_clk   (clk),
    .src_rst_n (rst_n),
    .src_word  (wp.ptr),
    .dst_clk   (rd_clk),
    .dst_rst_n (rd_rst_n_q),
    .dst_word  (wr_snap)
  );

  always_comb
  begin
    rd_act    = ~rd_en_n;
    rd_drive  = ~rd_out_en_n;
    // a clear seen while reads are held waits in rd_pend_q
    rd_clr_go = rd_act & (~rd_ptr_clear_n | rd_pend_q);
    rd_pend_d = rd_act ? 1'b0 : (rd_pend_q | ~rd_ptr_clear_n);
    rp.adv    = rd_act;
    rp.clr    = rd_clr_go;
    rd_addr   = rd_clr_go ? AW'(dcff_pkg::PTR_RESET) : rp.ptr;
    rd_word   = mem_q[rd_addr];
    dout_d    = (rd_act & rd_drive) ? rd_word : dout_q;
    // a raised test strap floats the bus rather than drive unknown data
    oe_n_d    = rd_out_en_n | tst_s2_q;
    if (wr_snap >= rp.ptr)
      lag = {1'b0, wr_snap} - {1'b0, rp.ptr};
    else
      lag = {1'b0, wr_snap} + WRAP - {1'b0, rp.ptr};
    // snapshot lags the live write pointer, so the flag is conservative
    lag_ok_d  = (lag >= LAG_MIN);
  end

  always_ff @(posedge rd_clk)
  begin
    if (!rd_rst_n_q)
    begin
      rd_pend_q <= 1'b0;
      dout_q    <= dcff_pkg::OUT_RESET;
      oe_n_q    <= 1'b1;
      lag_ok_q  <= 1'b0;
    end
    else
    begin
      rd_pend_q <= rd_pend_d;
      dout_q    <= dout_d;
      oe_n_q    <= oe_n_d;
      lag_ok_q  <= lag_ok_d;
    end
  end

  assign rd_byte_out  = dout_q;
  assign rd_byte_oe_n = oe_n_q;
  assign rd_lag_ok    = lag_ok_q;

  // checks, write domain
  wr_capture_a: assert property (@(posedge clk) disable iff (!rst_n)
    !wr_en_n |=> wb_vld_q && wb_data_q == $past(wr_byte_in))
    else $error("accepted byte not captured");

  wr_ptr_step_a: assert property (@(posedge clk) disable iff (!rst_n)
    !wr_en_n && !wr_clr_go && wp.ptr != LAST |=> wp.ptr == $past(wp.ptr) + AW'(1))
    else $error("write pointer did not step");

  wr_ptr_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
    wr_en_n |=> $stable(wp.ptr) && !wb_vld_q)
    else $error("write pointer moved while disabled");

  wr_clear_go_a: assert property (@(posedge clk) disable iff (!rst_n)
    !wr_en_n && !wr_ptr_clear_n |=> wb_addr_q == '0 && wp.ptr == AW'(1))
    else $error("write clear did not restart at word zero");

  wr_defer_clr_a: assert property (@(posedge clk) disable iff (!rst_n)
    wr_en_n && !wr_ptr_clear_n ##1 wr_en_n [*1] ##1 !wr_en_n |=> wb_addr_q == '0)
    else $error("deferred write clear lost");

  wr_wrap_a: assert property (@(posedge clk) disable iff (!rst_n)
    !wr_en_n && !wr_clr_go && wp.ptr == LAST |=> wp.ptr == '0)
    else $error("write pointer did not wrap");

  wr_ignore_a: assert property (@(posedge clk) disable iff (!rst_n)
    wr_en_n |=> $stable(wb_data_q))
    else $error("input byte taken while disabled");

  wr_addr_a: assert property (@(posedge clk) disable iff (!rst_n)
    !wr_en_n && !wr_clr_go |=> wb_addr_q == $past(wp.ptr))
    else $error("byte not aimed at the write pointer");

  wr_commit_a: assert property (@(posedge clk) disable iff (!rst_n)
    wb_vld_q |=> mem_q[$past(wb_addr_q)] == $past(wb_data_q))
    else $error("buffered byte not committed");

  wr_flush_a: assert property (@(posedge clk) disable iff (!rst_n)
    wr_clr_go |=> wb_vld_q && wb_addr_q == '0)
    else $error("clear did not flush the byte to word zero");

  wr_pend_set_a: assert property (@(posedge clk) disable iff (!rst_n)
    wr_en_n && !wr_ptr_clear_n |=> wr_pend_q)
    else $error("write clear not remembered");

  wr_pend_run_a: assert property (@(posedge clk) disable iff (!rst_n)
    !wr_en_n && wr_pend_q |=> wb_addr_q == '0)
    else $error("pending write clear not executed");

  wr_pend_drop_a: assert property (@(posedge clk) disable iff (!rst_n)
    !wr_en_n |=> !wr_pend_q)
    else $error("write clear left pending");

  // checks, refresh pacing
  refresh_gap_a: assert property (@(posedge clk) disable iff (!rst_n)
    refresh_stb |=> !refresh_stb [*8])
    else $error("refresh strobes too close");

  // checks, read domain
  rd_float_a: assert property (@(posedge rd_clk) disable iff (!rd_rst_n_q)
    rd_out_en_n |=> rd_byte_oe_n)
    else $error("outputs driven with drive enable high");

  rd_load_a: assert property (@(posedge rd_clk) disable iff (!rd_rst_n_q)
    !rd_en_n && !rd_out_en_n |=> rd_byte_out == $past(rd_word))
    else $error("read register not loaded");

  rd_skip_a: assert property (@(posedge rd_clk) disable iff (!rd_rst_n_q)
    !rd_en_n && rd_out_en_n && !rd_clr_go && rp.ptr != LAST
    |=> rp.ptr == $past(rp.ptr) + AW'(1) && $stable(rd_byte_out))
    else $error("skip read misbehaved");

  rd_hold_a: assert property (@(posedge rd_clk) disable iff (!rd_rst_n_q)
    rd_en_n |=> $stable(rp.ptr) && $stable(rd_byte_out))
    else $error("read pointer moved while disabled");

  rd_clear_a: assert property (@(posedge rd_clk) disable iff (!rd_rst_n_q)
    rd_clr_go |=> rp.ptr == AW'(1))
    else $error("read clear did not restart at word zero");

  rd_pend_set_a: assert property (@(posedge rd_clk) disable iff (!rd_rst_n_q)
    rd_en_n && !rd_ptr_clear_n |=> rd_pend_q)
    else $error("read clear not remembered");

  rd_pend_drop_a: assert property (@(posedge rd_clk) disable iff (!rd_rst_n_q)
    !rd_en_n |=> !rd_pend_q)
    else $error("read clear left pending");

  rd_defer_clr_a: assert property (@(posedge rd_clk) disable iff (!rd_rst_n_q)
    rd_en_n && !rd_ptr_clear_n ##1 rd_en_n ##1 !rd_en_n |=> rp.ptr == AW'(1))
    else $error("deferred read clear lost");

  rd_prefetch_a: assert property (@(posedge rd_clk) disable iff (!rd_rst_n_q)
    rd_clr_go && !rd_out_en_n |=> rd_byte_out == $past(mem_q[0]))
    else $error("clear did not fetch word zero");

  rd_drive_a: assert property (@(posedge rd_clk) disable iff (!rd_rst_n_q)
    !rd_out_en_n && !tst_s2_q |=> !rd_byte_oe_n)
    else $error("outputs floated with drive enable low");

  rd_noload_a: assert property (@(posedge rd_clk) disable iff (!rd_rst_n_q)
    rd_out_en_n |=> $stable(rd_byte_out))
    else $error("read register loaded while floated");

  rd_lag_low_a: assert property (@(posedge rd_clk) disable iff (!rd_rst_n_q)
    wr_snap == rp.ptr |=> !rd_lag_ok)
    else $error("lag flag set with equal pointers");

  rd_lag_high_a: assert property (@(posedge rd_clk) disable iff (!rd_rst_n_q)
    {1'b0, wr_snap} >= {1'b0, rp.ptr} + LAG_MIN |=> rd_lag_ok)
    else $error("lag flag clear with enough lag");
endmodule : dcff_field_fifo

// File: test/dcff_ctrl_model.sv
// controller model: free-running read clock and the factory test strap
`timescale 1ns/1ps
module dcff_ctrl_model (
  output logic rd_clk,
  output logic factory_test_pin
);
  // clock never stops between transfers, the bench paces traffic with the enables
  initial
  begin
    factory_test_pin = 1'b0;
    rd_clk           = 1'b0;
    #3.7;
    forever #6 rd_clk = ~rd_clk;
  end
endmodule : dcff_ctrl_model

// File: test/dual_clock_field_fifo_control_tb.sv
// self-checking bench for the dual-clock field fifo
`timescale 1ns/1ps
module dual_clock_field_fifo_control_tb;
  logic       clk;
  logic       rst_n;
  logic       wr_en_n;
  logic       wr_ptr_clear_n;
  logic [7:0] wr_byte_in;
  logic       rd_clk;
  logic       rd_en_n;
  logic       rd_out_en_n;
  logic       rd_ptr_clear_n;
  logic       factory_test_pin;
  logic [7:0] rd_byte_out;
  logic       rd_byte_oe_n;
  logic       rd_lag_ok;
  logic       refresh_stb;
  int         errors;
  int         checked;
  int         cycles;

  initial clk = 1'b0;
  always #2.5 clk = ~clk;

  dcff_field_fifo dcff_field_fifo_inst (
    .clk              (clk),
    .rst_n            (rst_n),
    .wr_en_n          (wr_en_n),
    .wr_ptr_clear_n   (wr_ptr_clear_n),
    .wr_byte_in       (wr_byte_in),
    .rd_clk           (rd_clk),
    .rd_en_n          (rd_en_n),
    .rd_out_en_n      (rd_out_en_n),
    .rd_ptr_clear_n   (rd_ptr_clear_n),
    .factory_test_pin (factory_test_pin),
    .rd_byte_out      (rd_byte_out),
    .rd_byte_oe_n     (rd_byte_oe_n),
    .rd_lag_ok        (rd_lag_ok),
    .refresh_stb      (refresh_stb)
  );

  dcff_ctrl_model dcff_ctrl_model_inst (
    .rd_clk           (rd_clk),
    .factory_test_pin (factory_test_pin)
  );

  function automatic logic [7:0] pat(input int i);
    return 8'(i * 37 + 11);
  endfunction : pat

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    checked++;
    if (got !== exp)
    begin
      errors++;
      $display("[FAIL] %0t %s: got %h want %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic wcyc(input logic en_n, input logic clr_n, input logic [7:0] d);
    wr_en_n        = en_n;
    wr_ptr_clear_n = clr_n;
    wr_byte_in     = d;
    @(posedge clk);
    #1;
  endtask : wcyc

  task automatic rcyc(input logic en_n, input logic oe_n, input logic clr_n);
    rd_en_n        = en_n;
    rd_out_en_n    = oe_n;
    rd_ptr_clear_n = clr_n;
    @(posedge rd_clk);
    #1;
  endtask : rcyc

  task automatic t_write;
    int n;
    n = 0;
    @(posedge clk);
    #1;
    repeat (3) wcyc(1'b0, 1'b1, 8'hEE);
    wcyc(1'b1, 1'b0, 8'h5A);
    wcyc(1'b1, 1'b1, 8'h5A);
    for (int i = 0; n < 160; i++)
    begin
      if (i % 16 == 5)
        wcyc(1'b1, 1'b1, ~pat(n));
      else
      begin
        wcyc(1'b0, 1'b1, pat(n));
        n++;
      end
    end
    wcyc(1'b1, 1'b1, 8'h00);
    repeat (8) @(posedge rd_clk);
    #1;
    chk({7'h00, rd_lag_ok}, 8'h01, "lag flag");
    $display("test write done");
  endtask : t_write

  task automatic t_read;
    @(posedge rd_clk);
    #1;
    rcyc(1'b1, 1'b0, 1'b1);
    chk({7'h00, rd_byte_oe_n}, 8'h00, "drive on");
    chk(rd_byte_out, 8'h00, "no load while disabled");
    for (int i = 0; i < 5; i++)
    begin
      rcyc(1'b0, 1'b0, 1'b1);
      chk(rd_byte_out, pat(i), "read");
    end
    repeat (3) rcyc(1'b0, 1'b1, 1'b1);
    chk({7'h00, rd_byte_oe_n}, 8'h01, "float");
    chk(rd_byte_out, pat(4), "skip no load");
    rcyc(1'b0, 1'b0, 1'b1);
    chk(rd_byte_out, pat(8), "after skip");
    repeat (2) rcyc(1'b1, 1'b0, 1'b1);
    chk(rd_byte_out, pat(8), "hold");
    rcyc(1'b0, 1'b0, 1'b1);
    chk(rd_byte_out, pat(9), "resume");
    rcyc(1'b1, 1'b0, 1'b0);
    rcyc(1'b1, 1'b0, 1'b1);
    chk(rd_byte_out, pat(9), "clear waits");
    rcyc(1'b0, 1'b0, 1'b1);
    chk(rd_byte_out, pat(0), "clear ran");
    rcyc(1'b0, 1'b0, 1'b1);
    chk(rd_byte_out, pat(1), "after clear");
    rcyc(1'b1, 1'b0, 1'b1);
    $display("test read done");
  endtask : t_read

  task automatic t_refresh;
    int n;
    n = 0;
    @(posedge clk);
    #1;
    repeat (640)
    begin
      @(posedge clk);
      #1;
      if (refresh_stb === 1'b1)
        n++;
    end
    chk(8'(n), 8'h0A, "refresh pulses");
    $display("test refresh done");
  endtask : t_refresh

  task automatic t_reset;
    repeat (8) @(posedge clk);
    #1;
    rst_n = 1'b1;
    // the read side sees the release through its own two-stage sync
    repeat (4) @(posedge rd_clk);
    #1;
    chk({7'h00, rd_lag_ok}, 8'h00, "lag flag at reset");
    chk({7'h00, rd_byte_oe_n}, 8'h01, "float at reset");
    chk(rd_byte_out, dcff_pkg::OUT_RESET, "data at reset");
    // 0.1ms of idle clocks before the controller clears both pointers
    repeat (20000) @(posedge clk);
    #1;
    wcyc(1'b1, 1'b0, 8'h00);
    wcyc(1'b1, 1'b1, 8'h00);
    @(posedge rd_clk);
    #1;
    rcyc(1'b1, 1'b1, 1'b0);
    rcyc(1'b1, 1'b1, 1'b1);
    $display("test reset done");
  endtask : t_reset

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : tally_and_finish

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 25000)
    begin
      errors++;
      $display("[FAIL] %0t run too long", $time);
      tally_and_finish();
    end
  end

  initial
  begin
    errors         = 0;
    checked        = 0;
    cycles         = 0;
    rst_n          = 1'b0;
    wr_en_n        = 1'b1;
    wr_ptr_clear_n = 1'b1;
    wr_byte_in     = 8'h00;
    rd_en_n        = 1'b1;
    rd_out_en_n    = 1'b1;
    rd_ptr_clear_n = 1'b1;
    t_reset();
    t_write();
    t_read();
    t_refresh();
    tally_and_finish();
  end
endmodule : dual_clock_field_fifo_control_tb
